// File: verilog/txcad_pkg.sv
// constants shared by the transmit command-a decoder and its helpers
// assumes one 100 MHz clock and a synchronous active-high reset
package txcad_pkg;

    // ********************************
    // command word layout
    // ********************************
    localparam int WORD_W      = 32;
    localparam int OFS_W       = 2;
    localparam int SIZE_W      = 11;
    localparam int TOTAL_W     = 16;
    localparam int BE_W        = 4;
    localparam int CMDA_OFS_LO = 16;
    localparam int CMDA_OFS_HI = 17;
    localparam int CMDA_FS_BIT = 13;
    localparam int CMDA_LS_BIT = 12;
    localparam int SIZE_LO     = 0;
    localparam int SIZE_HI     = 10;
    localparam int FLEN_LO     = 16;

    // ********************************
    // register map, byte addresses
    // ********************************
    localparam int ADDR_W               = 8;
    localparam logic [7:0] REG_CTRL     = 8'h00;
    localparam logic [7:0] REG_STATUS   = 8'h04;
    localparam logic [7:0] REG_MASK     = 8'h08;
    localparam logic [7:0] REG_LAST_CMD = 8'h0c;
    localparam logic [7:0] REG_TOTAL    = 8'h10;

    // status and mask bit positions
    localparam int EV_W        = 3;
    localparam int EV_TX_ERR   = 0;
    localparam int EV_FRAME_OK = 1;
    localparam int EV_BUF_DONE = 2;

    // ********************************
    // reset values
    // ********************************
    localparam logic             CTRL_EN_RST = 1'b1;
    localparam logic [EV_W-1:0]  MASK_RST    = 3'h0;
    localparam logic [EV_W-1:0]  STATUS_RST  = 3'h0;

    typedef enum logic [1:0] {
        PH_CMD_A,
        PH_CMD_B,
        PH_DATA
    } txcad_phase_e;

endpackage

// File: verilog/txcad_span.sv
// word span and byte enables of one transmit buffer
// assumes offset and size come from a latched command-a word
module txcad_span (
    input  wire logic [txcad_pkg::OFS_W-1:0]  offset,
    input  wire logic [txcad_pkg::SIZE_W-1:0] size,
    output logic      [txcad_pkg::SIZE_W-1:0] n_words,
    output logic      [txcad_pkg::OFS_W-1:0]  trail,
    output logic      [txcad_pkg::BE_W-1:0]   first_be,
    output logic      [txcad_pkg::BE_W-1:0]   last_be
);
    import txcad_pkg::*;

    logic [SIZE_W:0] span;

    // ********************************
    // span arithmetic
    // ********************************
    always_comb begin
        span     = {1'b0, size} + {{(SIZE_W-1){1'b0}}, offset};
        n_words  = {1'b0, span[SIZE_W:2]} + {{(SIZE_W-1){1'b0}}, |span[1:0]};
        // padding bytes to the next word boundary are counted, never sent
        trail    = OFS_W'(2'h0 - span[1:0]);
        first_be = BE_W'(4'hf << offset);
        last_be  = (span[1:0] == 2'h0) ? 4'hf : BE_W'(4'hf >> trail);
    end

endmodule

// File: verilog/txcad_irq.sv
// sticky event bits, write-one-to-clear, with a mask onto one level interrupt
// assumes events are single-cycle pulses from the same clock
module txcad_irq #(
    parameter int W = 3
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] events,
    input  wire logic         wr_status,
    input  wire logic         wr_mask,
    input  wire logic [W-1:0] wdata,
    output logic      [W-1:0] status,
    output logic      [W-1:0] mask,
    output logic              irq
);
    import txcad_pkg::*;

    typedef struct packed {
        logic [W-1:0] status;
        logic [W-1:0] mask;
    } txcad_irq_s;

    txcad_irq_s st_ff;
    txcad_irq_s nxt_st;

    // ********************************
    // sticky bits
    // ********************************
    always_comb begin
        nxt_st = st_ff;
        // a new event in the clearing cycle survives: set wins
        if (wr_status) begin
            nxt_st.status = st_ff.status & ~wdata;
        end
        nxt_st.status = nxt_st.status | events;
        if (wr_mask) begin
            nxt_st.mask = wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_ff.status <= W'(STATUS_RST);
            st_ff.mask   <= W'(MASK_RST);
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign status = st_ff.status;
    assign mask   = st_ff.mask;
    assign irq    = |(st_ff.status & st_ff.mask);

endmodule

// File: verilog/txcad_decoder.sv
// transmit buffer command decoder: parses command a/b, passes data words with
// byte enables, sums buffer sizes per frame and flags a frame length mismatch
// assumes words arrive in buffer order from the transmit fifo on the same clock
//
// Functional notes
// - bits 17:16 of command a give the first data byte offset, zero to three
// - bit 13 of command a set marks the buffer as a frame's first segment
// - bit 12 of command a set marks the buffer as a frame's last segment
// - bits 10:0 of command a give the buffer byte count after both commands
// - offset plus count gives trailing pad bytes, which are skipped
// - buffer byte counts are summed across all buffers of one frame
// - the sum differing from command b frame length sets the transmit error flag
// - every buffer starts with two command words; data starts at word three
// - bits 10:0 of command b give the whole frame's byte count
// - a transmit error shows in the status register and on the event output
//
// Implementation choices: the address-and-strobe port and the address map.
module txcad_decoder (
    input  wire logic                            clk,
    input  wire logic                            rst,
    input  wire logic                            in_valid,
    input  wire logic [txcad_pkg::WORD_W-1:0]    in_data,
    input  wire logic [txcad_pkg::ADDR_W-1:0]    reg_addr,
    input  wire logic [txcad_pkg::WORD_W-1:0]    reg_wdata,
    input  wire logic                            reg_wr,
    input  wire logic                            reg_rd,
    output logic      [txcad_pkg::WORD_W-1:0]    reg_rdata,
    output logic                                 out_valid,
    output logic      [txcad_pkg::WORD_W-1:0]    out_data,
    output logic      [txcad_pkg::BE_W-1:0]      out_be,
    output logic                                 out_sof,
    output logic                                 out_eof,
    output logic                                 transmit_error_flag,
    output logic                                 irq
);
    import txcad_pkg::*;

    typedef struct packed {
        txcad_phase_e        phase;
        logic                enable;
        logic [OFS_W-1:0]    offset;
        logic                first_seg;
        logic                last_seg;
        logic [SIZE_W-1:0]   size;
        logic [SIZE_W-1:0]   frame_len;
        logic [TOTAL_W-1:0]  total;
        logic [SIZE_W-1:0]   words_left;
        logic                first_word;
        logic [WORD_W-1:0]   rdata;
        logic                out_valid;
        logic [WORD_W-1:0]   out_data;
        logic [BE_W-1:0]     out_be;
        logic                out_sof;
        logic                out_eof;
        logic                err;
    } txcad_dec_s;

    txcad_dec_s        st_ff;
    txcad_dec_s        nxt_st;
    logic [SIZE_W-1:0] span_words;
    logic [OFS_W-1:0]  span_trail;
    logic [BE_W-1:0]   span_first_be;
    logic [BE_W-1:0]   span_last_be;
    logic [EV_W-1:0]   events;
    logic [EV_W-1:0]   status;
    logic [EV_W-1:0]   mask;
    logic              wr_status;
    logic              wr_mask;
    logic [TOTAL_W-1:0] sum_new;
    logic               take_a;
    logic               take_b;
    logic               take_d;

    // ********************************
    // helpers
    // ********************************
    txcad_span u_span (
        .offset   (st_ff.offset),
        .size     (st_ff.size),
        .n_words  (span_words),
        .trail    (span_trail),
        .first_be (span_first_be),
        .last_be  (span_last_be)
    );

    txcad_irq #(.W(EV_W)) u_irq (
        .clk       (clk),
        .rst       (rst),
        .events    (events),
        .wr_status (wr_status),
        .wr_mask   (wr_mask),
        .wdata     (reg_wdata[EV_W-1:0]),
        .status    (status),
        .mask      (mask),
        .irq       (irq)
    );

    // ********************************
    // parser and registers
    // ********************************
    always_comb begin
        nxt_st           = st_ff;
        nxt_st.out_valid = 1'b0;
        nxt_st.err       = 1'b0;
        nxt_st.rdata     = '0;
        events           = '0;
        wr_status        = 1'b0;
        wr_mask          = 1'b0;
        // disabling blocks only command a, so a buffer already under way still finishes
        take_a           = in_valid && (st_ff.phase == PH_CMD_A) && st_ff.enable;
        take_b           = in_valid && (st_ff.phase == PH_CMD_B);
        take_d           = in_valid && (st_ff.phase == PH_DATA);
        // the total is wider than a length, so an overflowing frame cannot alias to a match
        sum_new          = st_ff.first_seg ? TOTAL_W'(st_ff.size)
                                           : st_ff.total + TOTAL_W'(st_ff.size);

        case (st_ff.phase)
            PH_CMD_A: begin
                // reserved bits 31:18, 15:14 and 11 are never looked at
                if (take_a) begin
                    nxt_st.offset    = in_data[CMDA_OFS_HI:CMDA_OFS_LO];
                    nxt_st.first_seg = in_data[CMDA_FS_BIT];
                    nxt_st.last_seg  = in_data[CMDA_LS_BIT];
                    nxt_st.size      = in_data[SIZE_HI:SIZE_LO];
                    nxt_st.phase     = PH_CMD_B;
                end
            end
            PH_CMD_B: begin
                if (take_b) begin
                    nxt_st.frame_len  = in_data[SIZE_HI:SIZE_LO];
                    nxt_st.total      = sum_new;
                    nxt_st.words_left = span_words;
                    nxt_st.first_word = 1'b1;
                    if (st_ff.last_seg) begin
                        // compare at the closing buffer only; mid-frame sums are partial
                        if (sum_new != TOTAL_W'(in_data[SIZE_HI:SIZE_LO])) begin
                            nxt_st.err = 1'b1;
                            events[EV_TX_ERR] = 1'b1;
                        end else begin
                            events[EV_FRAME_OK] = 1'b1;
                        end
                    end
                    // a size-zero buffer with offset zero ends at command b without any data word; a nonzero offset still takes one data word
                    if (span_words == '0) begin
                        events[EV_BUF_DONE] = 1'b1;
                        nxt_st.phase = PH_CMD_A;
                    end else begin
                        nxt_st.phase = PH_DATA;
                    end
                end
            end
            PH_DATA: begin
                if (take_d) begin
                    nxt_st.out_valid  = 1'b1;
                    nxt_st.out_data   = in_data;
                    // a one-word buffer needs both masks at once
                    nxt_st.out_be     = (st_ff.first_word ? span_first_be : 4'hf)
                                      & ((st_ff.words_left == SIZE_W'(1)) ? span_last_be : 4'hf);
                    nxt_st.out_sof    = st_ff.first_word && st_ff.first_seg;
                    nxt_st.out_eof    = (st_ff.words_left == SIZE_W'(1)) && st_ff.last_seg;
                    nxt_st.first_word = 1'b0;
                    nxt_st.words_left = st_ff.words_left - SIZE_W'(1);
                    if (st_ff.words_left == SIZE_W'(1)) begin
                        events[EV_BUF_DONE] = 1'b1;
                        nxt_st.phase = PH_CMD_A;
                    end
                end
            end
            default: begin
                nxt_st.phase = PH_CMD_A;
            end
        endcase

        // register writes
        // unmapped addresses and read-only registers let a write fall through untouched
        if (reg_wr) begin
            if (reg_addr == REG_CTRL) begin
                nxt_st.enable = reg_wdata[0];
            end else if (reg_addr == REG_STATUS) begin
                wr_status = 1'b1;
            end else if (reg_addr == REG_MASK) begin
                wr_mask = 1'b1;
            end
        end

        // register reads; unmapped addresses read as zero
        if (reg_rd) begin
            if (reg_addr == REG_CTRL) begin
                nxt_st.rdata = {31'h0, st_ff.enable};
            end else if (reg_addr == REG_STATUS) begin
                nxt_st.rdata = {{(WORD_W-EV_W){1'b0}}, status};
            end else if (reg_addr == REG_MASK) begin
                nxt_st.rdata = {{(WORD_W-EV_W){1'b0}}, mask};
            end else if (reg_addr == REG_LAST_CMD) begin
                nxt_st.rdata[CMDA_OFS_HI:CMDA_OFS_LO] = st_ff.offset;
                nxt_st.rdata[CMDA_FS_BIT]             = st_ff.first_seg;
                nxt_st.rdata[CMDA_LS_BIT]             = st_ff.last_seg;
                nxt_st.rdata[SIZE_HI:SIZE_LO]         = st_ff.size;
            end else if (reg_addr == REG_TOTAL) begin
                nxt_st.rdata[TOTAL_W-1:0]               = st_ff.total;
                nxt_st.rdata[FLEN_LO+SIZE_W-1:FLEN_LO]  = st_ff.frame_len;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            // everything clears, then phase and enable take their own reset values
            st_ff        <= '0;
            st_ff.phase  <= PH_CMD_A;
            st_ff.enable <= CTRL_EN_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign reg_rdata           = st_ff.rdata;
    assign out_valid           = st_ff.out_valid;
    assign out_data            = st_ff.out_data;
    assign out_be              = st_ff.out_be;
    assign out_sof             = st_ff.out_sof;
    assign out_eof             = st_ff.out_eof;
    assign transmit_error_flag = st_ff.err;

    // ********************************
    // checks
    // ********************************
    // every check runs on the one clock and stays quiet while reset is held
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    offset_field_a: assert property (take_a |=> st_ff.offset == $past(in_data[17:16]))
        else $error("data start offset not taken from bits 17:16");
    first_seg_a: assert property (take_a && in_data[13] |=> st_ff.first_seg)
        else $error("first segment bit not taken");
    last_seg_a: assert property (take_a && in_data[12] |=> st_ff.last_seg)
        else $error("last segment bit not taken");
    buf_size_a: assert property (take_a |=> st_ff.size == $past(in_data[10:0]))
        else $error("buffer size not taken from bits 10:0");
    trail_skip_a: assert property (take_d && st_ff.words_left == 11'h1 && span_trail != 2'h0
                                   |=> out_valid && !out_be[3])
        else $error("trailing pad byte passed on");
    run_sum_a: assert property (take_b && !st_ff.first_seg
                                |=> st_ff.total == $past(st_ff.total) + 16'($past(st_ff.size)))
        else $error("running total not accumulated");
    len_err_a: assert property (take_b && st_ff.last_seg && sum_new != 16'(in_data[10:0])
                                |=> transmit_error_flag ##1 status[0])
        else $error("length mismatch not flagged");
    no_false_err_a: assert property (transmit_error_flag |-> $past(take_b) && $past(st_ff.last_seg))
        else $error("error flag without closing buffer");
    data_start_a: assert property (out_valid |-> $past(st_ff.phase) == PH_DATA)
        else $error("data word passed outside data phase");
    frame_len_a: assert property (take_b |=> st_ff.frame_len == $past(in_data[10:0]))
        else $error("frame length not taken from command b");
    err_report_a: assert property (transmit_error_flag |=> status[0] && (!mask[0] || irq))
        else $error("transmit error not in status or interrupt");
    sum_clear_a: assert property (take_b && st_ff.first_seg |=> st_ff.total == 16'($past(st_ff.size)))
        else $error("running total not restarted on first segment");
    sum_hold_a: assert property (!take_b |=> st_ff.total == $past(st_ff.total))
        else $error("running total moved outside command b");
    len_ok_a: assert property (take_b && st_ff.last_seg && sum_new == 16'(in_data[10:0])
                               |=> !transmit_error_flag)
        else $error("error flag on a matching frame length");
    err_pulse_a: assert property (transmit_error_flag |=> !transmit_error_flag)
        else $error("error flag longer than one cycle");
    err_status_a: assert property (transmit_error_flag |-> status[0])
        else $error("error flag without status bit");

    // ********************************
    // stream checks
    // ********************************
    first_lane_a: assert property (take_d && st_ff.first_word
                                   |=> out_be[0] == ($past(st_ff.offset) == 2'h0))
        else $error("first byte lane does not follow the offset");
    sof_mark_a: assert property (take_d && st_ff.first_word && st_ff.first_seg |=> out_valid && out_sof)
        else $error("start of frame not marked");
    eof_mark_a: assert property (take_d && st_ff.words_left == 11'h1 && st_ff.last_seg |=> out_eof)
        else $error("end of frame not marked");
    mid_lanes_a: assert property (take_d && !st_ff.first_word && st_ff.words_left != 11'h1
                                  |=> out_be == 4'hf)
        else $error("inner data word lost bytes");
    last_lane_a: assert property (take_d && st_ff.words_left == 11'h1 && span_trail == 2'h0
                                  |=> out_be[3])
        else $error("full last word lost its top byte");
    cmd_b_next_a: assert property (take_a |=> st_ff.phase == PH_CMD_B)
        else $error("command a not followed by command b");
    no_cmd_data_a: assert property (take_a || take_b |=> !out_valid)
        else $error("command word passed on as data");
    empty_buf_a: assert property (take_b && st_ff.size == 11'h0 && st_ff.offset == 2'h0
                                  |=> st_ff.phase == PH_CMD_A)
        else $error("empty buffer did not return to command a");
    dis_drop_a: assert property (in_valid && st_ff.phase == PH_CMD_A && !st_ff.enable |=> !out_valid)
        else $error("word passed while decoder disabled");

    // ********************************
    // scenario covers
    // ********************************
    good_frame_c: cover property (take_b && st_ff.last_seg && !st_ff.first_seg ##1 !transmit_error_flag);
    zero_buf_c:   cover property (take_b && st_ff.size == 11'h0);
    mid_buf_c:    cover property (take_b && !st_ff.first_seg && !st_ff.last_seg);
    bad_frame_c:  cover property (transmit_error_flag);
    pad_word_c:   cover property (out_valid && out_eof && out_be != 4'hf);

endmodule

// File: bench/txcad_host_model.sv
// host driver model: writes command-prefixed transmit buffers into the word stream
// assumes the bench calls send_buffer and that the decoder takes every valid word
module txcad_host_model (
    input  wire logic                         clk,
    output logic                              in_valid,
    output logic      [txcad_pkg::WORD_W-1:0] in_data
);
    timeunit 1ns;
    timeprecision 1ps;
    import txcad_pkg::*;

    initial begin
        in_valid = 1'b0;
        in_data  = 32'h0;
    end

    // ****************************************
    // one buffer: command a, command b, data
    // ****************************************
    // rsv fills the reserved bits with ones, a fault that only a scenario asks for
    task automatic send_buffer(input logic [1:0] ofs, input logic [10:0] size, input logic first,
                               input logic last, input logic [10:0] flen, input logic rsv);
        int          n;
        logic [31:0] w[$];
        n = (int'(ofs) + int'(size) + 3) / 4;
        w.push_back({{14{rsv}}, ofs, {2{rsv}}, first, last, rsv, size});
        w.push_back({21'h0, flen});
        for (int i = 0; i < n; i++) begin
            w.push_back({16'h5a00 + 16'(i), 5'h0, size});
        end
        foreach (w[k]) begin
            @(posedge clk);
            in_valid <= 1'b1;
            in_data  <= w[k];
        end
        @(posedge clk);
        in_valid <= 1'b0;
        // released stream shows the inverse so a stale word never looks valid
        in_data  <= ~w[w.size()-1];
    endtask
endmodule

// File: bench/tx_buffer_command_a_decoder_tb.sv
// testbench for the transmit command-a decoder: register tasks and buffer scenarios
// assumes the host model feeds the word stream; one 100 MHz clock, synchronous reset
module tx_buffer_command_a_decoder_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import txcad_pkg::*;

    logic              clk;
    logic              rst;
    logic              in_valid;
    logic [WORD_W-1:0] in_data;
    logic [ADDR_W-1:0] reg_addr;
    logic [WORD_W-1:0] reg_wdata;
    logic              reg_wr;
    logic              reg_rd;
    logic [WORD_W-1:0] reg_rdata;
    logic              out_valid;
    logic [WORD_W-1:0] out_data;
    logic [BE_W-1:0]   out_be;
    logic              out_sof;
    logic              out_eof;
    logic              transmit_error_flag;
    logic              irq;
    int                n_fail;
    int                num_checks;
    int                n_txerr;
    logic [37:0]       mon_q[$];

    txcad_decoder uut (.clk(clk), .rst(rst), .in_valid(in_valid), .in_data(in_data), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .out_valid(out_valid), .out_data(out_data), .out_be(out_be), .out_sof(out_sof),
        .out_eof(out_eof), .transmit_error_flag(transmit_error_flag), .irq(irq));
    txcad_host_model host (.clk(clk), .in_valid(in_valid), .in_data(in_data));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        if (out_valid === 1'b1) mon_q.push_back({out_sof, out_eof, out_be, out_data});
        if (transmit_error_flag === 1'b1) n_txerr++;
    end

    // ****************************************
    // tasks
    // ****************************************
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0d ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe, so sample just past that edge
    task automatic reg_read(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1;
        check(64'(reg_rdata), 64'(exp));
    endtask

    function automatic logic [3:0] exp_be(int ofs, int size, int i);
        logic [3:0] be;
        for (int b = 0; b < 4; b++) be[b] = (i * 4 + b >= ofs) && (i * 4 + b < ofs + size);
        return be;
    endfunction

    task automatic run_buf(input int ofs, input int size, input logic first, input logic last,
                           input int flen, input logic rsv);
        int          n;
        logic [37:0] e;
        n = (ofs + size + 3) / 4;
        mon_q.delete();
        host.send_buffer(2'(ofs), 11'(size), first, last, 11'(flen), rsv);
        repeat (3) @(posedge clk);
        check(64'(mon_q.size()), 64'(n));
        for (int i = 0; i < n; i++) begin
            e = {first && (i == 0), last && (i == n - 1), exp_be(ofs, size, i), 16'h5a00 + 16'(i), 5'h0, 11'(size)};
            check(64'(mon_q[i]), 64'(e));
        end
    endtask

    task automatic results();
        $display("checks %0d, mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        n_fail++;
        results();
    end

    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        rst       = 1'b1;
        reg_addr  = 8'h0;
        reg_wdata = 32'h0;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        reg_read(REG_CTRL, 32'h1);
        reg_read(REG_STATUS, 32'h0);
        reg_read(REG_MASK, 32'h0);
        reg_write(8'h14, 32'hffffffff);
        reg_read(8'h14, 32'h0);
        reg_write(REG_MASK, 32'h7);
        // reserved bits all ones must change nothing
        run_buf(1, 5, 1'b1, 1'b1, 5, 1'b1);
        reg_read(REG_LAST_CMD, 32'h00013005);
        reg_read(REG_STATUS, 32'h6);
        check({63'h0, irq}, 64'h1);
        reg_write(REG_STATUS, 32'h7);
        reg_read(REG_STATUS, 32'h0);
        check({63'h0, irq}, 64'h0);
        for (int o = 0; o < 4; o++) begin
            run_buf(o, 1, 1'b1, 1'b1, 1, 1'b0);
            run_buf(o, 2, 1'b1, 1'b1, 2, 1'b0);
            run_buf(o, 6, 1'b1, 1'b1, 6, 1'b0);
        end
        check(64'(n_txerr), 64'h0);
        // three-buffer frame, sum matches
        reg_write(REG_STATUS, 32'h7);
        run_buf(0, 3, 1'b1, 1'b0, 9, 1'b0);
        run_buf(2, 4, 1'b0, 1'b0, 9, 1'b0);
        run_buf(3, 2, 1'b0, 1'b1, 9, 1'b0);
        reg_read(REG_TOTAL, {5'h0, 11'h9, 16'h9});
        reg_read(REG_STATUS, 32'h6);
        check(64'(n_txerr), 64'h0);
        // frame length one byte longer than the buffers carry
        reg_write(REG_STATUS, 32'h7);
        reg_write(REG_MASK, 32'h1);
        run_buf(0, 3, 1'b1, 1'b0, 10, 1'b0);
        run_buf(1, 6, 1'b0, 1'b1, 10, 1'b0);
        check(64'(n_txerr), 64'h1);
        reg_read(REG_STATUS, 32'h5);
        check({63'h0, irq}, 64'h1);
        reg_write(REG_MASK, 32'h2);
        // the mask lands at the edge that ends the write, so look just past it
        #1;
        check({63'h0, irq}, 64'h0);
        reg_write(REG_STATUS, 32'h7);
        // abandoned frame, then a new first segment of size zero must restart the sum
        run_buf(0, 5, 1'b1, 1'b0, 5, 1'b0);
        run_buf(0, 0, 1'b1, 1'b0, 4, 1'b0);
        run_buf(1, 4, 1'b0, 1'b1, 4, 1'b0);
        check(64'(n_txerr), 64'h1);
        reg_read(REG_STATUS, 32'h6);
        // disabled decoder drops the whole buffer
        reg_write(REG_STATUS, 32'h7);
        reg_write(REG_CTRL, 32'h0);
        mon_q.delete();
        host.send_buffer(2'h0, 11'h4, 1'b1, 1'b1, 11'h4, 1'b0);
        repeat (3) @(posedge clk);
        check(64'(mon_q.size()), 64'h0);
        reg_read(REG_STATUS, 32'h0);
        reg_write(REG_CTRL, 32'h1);
        run_buf(0, 4, 1'b1, 1'b1, 3, 1'b0);
        check(64'(n_txerr), 64'h2);
        results();
    end
endmodule
